// *** accel_irq_route_offset_regs.sv ***
// Routing, enable, polarity and axis offset registers with pin outputs.
// Assumes one-cycle strobes; read data valid the cycle after read strobe.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ns
module accel_irq_route_offset_regs
  import irq_route_pkg::*;
#(
  parameter int W = SAMPLE_W
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  input wire logic sleep_wake_event,
  input wire logic orientation_event,
  input wire logic freefall_motion_event,
  input wire logic data_ready_event,
  input wire logic [W-1:0] sample_x,
  input wire logic [W-1:0] sample_y,
  input wire logic [W-1:0] sample_z,
  input wire logic sample_valid,
  output logic [W-1:0] out_x,
  output logic [W-1:0] out_y,
  output logic [W-1:0] out_z,
  output logic out_valid,
  output logic interrupt_pin_first,
  output logic interrupt_pin_second,
  output logic irq
);
  logic [7:0] interrupt_pin_routing_ff;
  logic [7:0] interrupt_enable_register_ff;
  logic [7:0] pin_ctrl_ff;
  logic [7:0] irq_mask_ff;
  logic [7:0] int_source_ff;
  logic [7:0] nxt_int_source;
  logic [7:0] offset_ff [3];
  logic [W-1:0] raw [3];
  logic [W-1:0] corr [3];
  logic [W-1:0] out_ff [3];
  logic [7:0] event_vec;
  logic [7:0] rd_mux;
  logic pin_first_c;
  logic pin_second_c;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction : hit

  assign event_vec = {sleep_wake_event, 2'b00, orientation_event, 1'b0,
                      freefall_motion_event, 1'b0, data_ready_event};
  assign raw[0] = sample_x;
  assign raw[1] = sample_y;
  assign raw[2] = sample_z;

  // Routing register: reserved bits are stored and reach the router, which masks them off with SOURCE_MASK
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      interrupt_pin_routing_ff <= RESET_BYTE;
    end else if (wr_stb && hit(addr, ADDR_ROUTING)) begin
      interrupt_pin_routing_ff <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      interrupt_enable_register_ff <= RESET_BYTE;
    end else if (wr_stb && hit(addr, ADDR_IRQ_ENABLE)) begin
      interrupt_enable_register_ff <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pin_ctrl_ff <= RESET_BYTE;
    end else if (wr_stb && hit(addr, ADDR_PIN_CTRL)) begin
      pin_ctrl_ff <= wdata & PIN_CTRL_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq_mask_ff <= RESET_BYTE;
    end else if (wr_stb && hit(addr, ADDR_IRQ_MASK)) begin
      irq_mask_ff <= wdata & SOURCE_MASK;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_axis
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          offset_ff[g] <= RESET_BYTE;
        end else if (wr_stb && hit(addr, ADDR_OFF_X + 8'(g))) begin
          offset_ff[g] <= wdata;
        end
      end

      axis_offset_add #(.W(W)) u_add (
        .raw(raw[g]),
        .offset(offset_ff[g]),
        .corrected(corr[g])
      );

      always_ff @(posedge clk) begin
        if (!reset_n) begin
          out_ff[g] <= '0;
        end else if (sample_valid) begin
          out_ff[g] <= corr[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      out_valid <= 1'b0;
    end else begin
      out_valid <= sample_valid;
    end
  end

  assign out_x = out_ff[0];
  assign out_y = out_ff[1];
  assign out_z = out_ff[2];

  // Sticky source flags; a new event beats the read clear
  always_comb begin
    nxt_int_source = int_source_ff;
    if (rd_stb && hit(addr, ADDR_INT_SOURCE)) begin
      nxt_int_source = '0;
    end
    nxt_int_source = nxt_int_source | (event_vec & SOURCE_MASK);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      int_source_ff <= RESET_BYTE;
    end else begin
      int_source_ff <= nxt_int_source;
    end
  end

  irq_pin_router u_router (
    .source_level(int_source_ff),
    .enable(interrupt_enable_register_ff),
    .routing(interrupt_pin_routing_ff),
    .polarity(pin_ctrl_ff[BIT_POLARITY]),
    .pin_first(pin_first_c),
    .pin_second(pin_second_c)
  );

  // Pins registered so outputs come straight from flops; one cycle late
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      interrupt_pin_first <= 1'b1;
      interrupt_pin_second <= 1'b1;
      irq <= 1'b0;
    end else begin
      interrupt_pin_first <= pin_first_c;
      interrupt_pin_second <= pin_second_c;
      irq <= |(nxt_int_source & irq_mask_ff);
    end
  end

  always_comb begin
    case (addr)
      ADDR_INT_SOURCE: rd_mux = int_source_ff;
      ADDR_PIN_CTRL: rd_mux = pin_ctrl_ff;
      ADDR_IRQ_ENABLE: rd_mux = interrupt_enable_register_ff;
      ADDR_ROUTING: rd_mux = interrupt_pin_routing_ff;
      ADDR_OFF_X: rd_mux = offset_ff[0];
      ADDR_OFF_Y: rd_mux = offset_ff[1];
      ADDR_OFF_Z: rd_mux = offset_ff[2];
      ADDR_IRQ_MASK: rd_mux = irq_mask_ff;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata <= 8'h00;
    end else if (rd_stb) begin
      rdata <= rd_mux;
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule : accel_irq_route_offset_regs

// *** irq_route_pkg.sv ***
// Constants for the interrupt routing and axis offset register bank.
// Assumes an 8-bit register port with 8-bit byte addresses.
// Notes on behaviour
// - Routing bit clear steers that source to the second interrupt pin.
// - Routing bit set steers that source to the first interrupt pin.
// - Sources routed to one pin are ORed onto it.
// - Routing bits: sleep/wake 7, orientation 4, freefall/motion 2, ready 0.
// - All routing bits reset to zero, so all sources go to second pin.
// - Offsets are two's complement, 1.96 mg per LSB.
// - Signed 8-bit offset gives about plus or minus 250 mg range.
// - X, Y, Z offsets at 0x2F, 0x30, 0x31, read and write.
// - Offset registers reset to zero.
// - A source reaches a pin only when its enable bit is set.
// - Polarity bit zero means active low pins.
package irq_route_pkg;
  localparam logic [7:0] ADDR_INT_SOURCE = 8'h0C;
  localparam logic [7:0] ADDR_PIN_CTRL = 8'h2C;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h2D;
  localparam logic [7:0] ADDR_ROUTING = 8'h2E;
  localparam logic [7:0] ADDR_OFF_X = 8'h2F;
  localparam logic [7:0] ADDR_OFF_Y = 8'h30;
  localparam logic [7:0] ADDR_OFF_Z = 8'h31;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h40;
  localparam logic [7:0] ADDR_SAMPLE_X = 8'h41;
  localparam int BIT_SLEEP_WAKE = 7;
  localparam int BIT_ORIENT = 4;
  localparam int BIT_FF_MOTION = 2;
  localparam int BIT_DATA_READY = 0;
  localparam int BIT_POLARITY = 1;
  localparam logic [7:0] SOURCE_MASK = 8'h95;
  localparam logic [7:0] PIN_CTRL_MASK = 8'h02;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Offset LSB 1.96 mg vs output LSB 3.9 mg at 2 g, 10 bit: shift right one
  localparam int OFFSET_SHIFT = 1;
  localparam int SAMPLE_W = 10;
endpackage : irq_route_pkg

// *** axis_offset_add.sv ***
// Adds one axis offset to a raw sample, saturating at the sample range.
// Assumes samples are signed and stable alongside their valid strobe.
`timescale 1ns/1ns
module axis_offset_add
  import irq_route_pkg::*;
#(
  parameter int W = SAMPLE_W
) (
  input wire logic [W-1:0] raw,
  input wire logic [7:0] offset,
  output logic [W-1:0] corrected
);
  logic signed [W+1:0] sum;
  logic signed [W+1:0] ext_off;
  localparam logic signed [W+1:0] MAXV = (W + 2)'((2 ** (W - 1)) - 1);
  localparam logic signed [W+1:0] MINV = (W + 2)'(-(2 ** (W - 1)));

  always_comb begin
    ext_off = (W + 2)'($signed(offset)) >>> OFFSET_SHIFT;
    sum = (W + 2)'($signed(raw)) + ext_off;
    if (sum > MAXV) begin
      corrected = MAXV[W-1:0];
    end else if (sum < MINV) begin
      corrected = MINV[W-1:0];
    end else begin
      corrected = sum[W-1:0];
    end
  end
endmodule : axis_offset_add

// *** irq_pin_router.sv ***
// Steers enabled sources onto the two interrupt pins.
// Assumes source levels are synchronous to the register clock.
`timescale 1ns/1ns
module irq_pin_router
  import irq_route_pkg::*;
(
  input wire logic [7:0] source_level,
  input wire logic [7:0] enable,
  input wire logic [7:0] routing,
  input wire logic polarity,
  output logic pin_first,
  output logic pin_second
);
  logic [7:0] live;
  logic any_first;
  logic any_second;

  always_comb begin
    live = source_level & enable & SOURCE_MASK;
    any_first = |(live & routing);
    any_second = |(live & ~routing);
    // Polarity low gives active-low pins
    pin_first = polarity ? any_first : ~any_first;
    pin_second = polarity ? any_second : ~any_second;
  end
endmodule : irq_pin_router

// *** accel_irq_route_offset_regs_sva.sv ***
// Checker for the routing bank port timing.
// Bound to the top module; sees its ports only.
`timescale 1ns/1ns
module accel_irq_route_offset_regs_sva
  import irq_route_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] addr,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] rdata,
  input wire logic sleep_wake_event,
  input wire logic orientation_event,
  input wire logic freefall_motion_event,
  input wire logic data_ready_event,
  input wire logic interrupt_pin_first,
  input wire logic interrupt_pin_second,
  input wire logic irq
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  wire any_ev = sleep_wake_event | orientation_event |
    freefall_motion_event | data_ready_event;
  // Pins are two stages from any cause
  wire cause = any_ev | wr_stb | rd_stb;
  sequence clear_src;
    rd_stb && addr == ADDR_INT_SOURCE && !any_ev;
  endsequence
  a_read_idle_zero: assert property (
    !$past(rd_stb) |-> rdata == 8'h00) else $error("rdata not idle");
  a_reset_pins_off: assert property (
    $rose(reset_n) |-> interrupt_pin_first && interrupt_pin_second && !irq)
    else $error("pins active at reset");
  a_unmapped_zero: assert property (
    rd_stb && addr == 8'h00 |=> rdata == 8'h00) else $error("unmapped");
  // A mask write reaches irq two edges later, an event one edge later
  a_irq_rise_cause: assert property (
    $rose(irq) |-> $past(any_ev) || $past(wr_stb, 2))
    else $error("irq no cause");
  a_first_pin_cause: assert property (
    $changed(interrupt_pin_first) |-> $past(cause, 2))
    else $error("first pin moved");
  a_second_pin_cause: assert property (
    $changed(interrupt_pin_second) |-> $past(cause, 2))
    else $error("second pin moved");
  a_clear_irq_low: assert property (
    clear_src |=> !irq) else $error("irq after clear");
  a_clear_pins_idle: assert property (
    clear_src |=> ##1 interrupt_pin_first == interrupt_pin_second)
    else $error("pin after clear");
endmodule : accel_irq_route_offset_regs_sva

// *** host_irq_model.sv ***
// Host side: turns pin levels into service requests.
// Assumes the bench mirrors the polarity bit it wrote.
`timescale 1ns/1ns
module host_irq_model (
  input wire logic interrupt_pin_first,
  input wire logic interrupt_pin_second,
  input wire logic polarity,
  output logic want_first,
  output logic want_second
);
  // A request leads the host to read the source register
  assign want_first = interrupt_pin_first == polarity;
  assign want_second = interrupt_pin_second == polarity;
endmodule : host_irq_model

// *** accel_irq_route_offset_regs_test.sv ***
// Bench for the routing and offset register bank.
// Assumes package, host model and checker compile first.
`timescale 1ns/1ns
module accel_irq_route_offset_regs_test;
  import irq_route_pkg::*;
  localparam int W = SAMPLE_W;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [3:0] ev = 4'h0;
  logic polarity = 1'b0;
  logic [W-1:0] sample_x = 10'h1F0;
  logic [W-1:0] sample_y = 10'h005;
  logic [W-1:0] sample_z = 10'h200;
  logic sample_valid = 1'b0;
  wire data_ready_event = ev[0];
  wire freefall_motion_event = ev[1];
  wire orientation_event = ev[2];
  wire sleep_wake_event = ev[3];
  wire [7:0] rdata;
  wire [W-1:0] out_x, out_y, out_z;
  wire out_valid, interrupt_pin_first, interrupt_pin_second, irq;
  wire want_first, want_second;
  int error_cnt = 0;
  int cmp_count = 0;
  int pos[4] = '{0, 2, 4, 7};
  accel_irq_route_offset_regs #(.W(W)) dut (.*);
  host_irq_model host (.*);
  initial forever #50 clk = ~clk;
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic chkb(input logic got, input logic exp);
    chk({9'h000, got}, {9'h000, exp});
  endtask : chkb
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 chk({2'b00, rdata}, {2'b00, e});
  endtask : rdc
  // Event high one cycle; pins settle two cycles on
  task automatic fire(input logic [3:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 4'h0;
    @(posedge clk);
    #1;
  endtask : fire
  task automatic report_and_stop;
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  initial begin
    #2000000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    for (int a = 8'h2C; a <= 8'h31; a++) rdc(8'(a), 8'h00);
    rdc(8'h00, 8'h00);
    chkb(want_first | want_second, 1'b0);
    for (int a = 0; a < 3; a++) wr(8'(8'h2F + a), 8'(8'h7F + a));
    for (int a = 0; a < 3; a++) rdc(8'(8'h2F + a), 8'(8'h7F + a));
    @(posedge clk);
    sample_valid <= 1'b1;
    @(posedge clk);
    sample_valid <= 1'b0;
    #1 chkb(out_valid, 1'b1);
    chk(out_x, 10'h1FF);
    chk(out_y, 10'h3C5);
    chk(out_z, 10'h200);
    @(posedge clk);
    #1 chkb(out_valid, 1'b0);
    wr(ADDR_IRQ_ENABLE, SOURCE_MASK);
    foreach (pos[i]) begin
      wr(ADDR_ROUTING, 8'h68 | (8'h01 << pos[i]));
      fire(4'(1 << i));
      chkb(want_first & !want_second, 1'b1);
      rdc(ADDR_INT_SOURCE, 8'h01 << pos[i]);
      wr(ADDR_ROUTING, 8'h00);
      fire(4'(1 << i));
      chkb(want_second & !want_first, 1'b1);
      rdc(ADDR_INT_SOURCE, 8'h01 << pos[i]);
    end
    wr(ADDR_IRQ_ENABLE, 8'h01);
    wr(ADDR_ROUTING, SOURCE_MASK);
    fire(4'h4);
    chkb(want_first, 1'b0);
    fire(4'h1);
    chkb(want_first, 1'b1);
    rdc(ADDR_INT_SOURCE, 8'h11);
    wr(ADDR_PIN_CTRL, 8'hFF);
    polarity <= 1'b1;
    @(posedge clk);
    #1 chkb(interrupt_pin_first | interrupt_pin_second, 1'b0);
    rdc(ADDR_PIN_CTRL, PIN_CTRL_MASK);
    fire(4'h1);
    chkb(interrupt_pin_first, 1'b1);
    wr(ADDR_IRQ_MASK, 8'h01);
    @(posedge clk);
    #1 chkb(irq, 1'b1);
    wr(ADDR_IRQ_MASK, 8'h04);
    rdc(ADDR_INT_SOURCE, 8'h01);
    fire(4'h1);
    chkb(irq, 1'b0);
    fire(4'h2);
    chkb(irq, 1'b1);
    rdc(ADDR_INT_SOURCE, 8'h05);
    chkb(irq, 1'b0);
    @(posedge clk);
    reset_n <= 1'b0;
    polarity <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rdc(ADDR_ROUTING, 8'h00);
    report_and_stop();
  end
endmodule : accel_irq_route_offset_regs_test
bind accel_irq_route_offset_regs accel_irq_route_offset_regs_sva chk_i (.*);
